// ### core/sla_pkg.sv
package sla_pkg;
    // Register byte addresses on the bus
    localparam logic [4:0] REG_CTRL       = 5'h00;
    localparam logic [4:0] REG_COUNT_LOW  = 5'h04;
    localparam logic [4:0] REG_CONFIG     = 5'h08;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] REG_IRQ_MASK   = 5'h10;

    // Field positions of the arbiter control register
    localparam int B_MODE_HI = 7;
    localparam int B_MODE_LO = 6;
    localparam int B_LOST    = 5;
    localparam int B_CLK_SEL = 4;
    localparam int B_DONE    = 3;
    localparam int B_RUN     = 2;
    localparam int B_OVF     = 1;
    localparam int B_MSB     = 0;

    // Field positions of the configuration register
    localparam int CFG_SRC     = 0;
    localparam int CFG_DIV_LSB = 8;

    // Interrupt status and mask bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVF  = 1;
    localparam int IRQ_LOST = 2;
    localparam int IRQ_W    = 3;

    // Arbiter modes
    localparam logic [1:0] MODE_IDLE    = 2'h0;
    localparam logic [1:0] MODE_BITTIME = 2'h1;
    localparam logic [1:0] MODE_ARB     = 2'h2;

    // Counter geometry and arbitration sample points
    localparam int         CNT_W      = 9;
    localparam logic [8:0] CNT_MAX    = 9'h1FF;
    localparam logic [8:0] TARGET_BUS = 9'h038;
    localparam logic [8:0] TARGET_PRE = 9'h008;

    // Bus clock divider for the counter clock
    localparam int         DIV_BUS      = 4;
    localparam logic [1:0] DIV_BUS_LAST = 2'(DIV_BUS - 1);

    // Reset values
    localparam logic [1:0] MODE_RST    = 2'h0;
    localparam logic [7:0] CFG_DIV_RST = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_STOP  = 4'b1000
    } sla_state_t;
endpackage

// ### core/sla_arbiter.sv
`timescale 1ns/1ps
// Contract
// - A 9-bit counter with overflow flag and mode control logic.
// - Mode field: 00 idle, 01 bit time, 10 arbitration, 11 reserved.
// - Reset clears the mode field, leaving the block idle.
// - Lost flag is read-only; cleared by writing 0 to upper mode bit or reset.
// - Clock select 1 uses half prescaler clock; 0 uses bus clock over four.
// - Clock select bit is read/write and cleared by reset.
// - Prescaler input is bus clock or crystal clock per a config bit.
// - Done flag sets at measurement end; control write or reset clears it.
// - Running flag reads 1 while counting, 0 when stopped; reset clears it.
// - Overflow flag sets on overflow; control write or reset clears it.
// - Count bit 8 in control, bits 7..0 in data; control write clears.
// - Mode 00 holds the counter reset and idle.
// - Bit time, select 0: run between two falling receive edges, then done.
// - Bit time, select 1: start on receive low, stop on rising edge.
// - Arbitration restarts the counter on each transmit output rising edge.
// - At count 38h or 08h sample receive once; low sets lost flag.
// - While lost is set, the transmit pin is forced high.
// - Transmit low without prior receive low resets counter, waits next rise.
module sla_arbiter
    import sla_pkg::*;
#(
    parameter int PRE_W = 8
)(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rxd,
    input  wire logic        crystal_clock,
    input  wire logic        internal_transmit_output,
    output logic             txd_pin,
    output logic             irq
);

    generate
        if (PRE_W < 1 || PRE_W > 8)
        begin : g_bad_pre
            $error("PRE_W must lie between 1 and 8");
        end
    endgenerate

    sla_state_t         state;
    sla_state_t         next_state;
    logic [CNT_W-1:0]   count;
    logic [CNT_W-1:0]   next_count;
    logic [1:0]         mode;
    logic [1:0]         next_mode;
    logic               clk_sel;
    logic               next_clk_sel;
    logic               done_flag;
    logic               next_done;
    logic               ovf_flag;
    logic               next_ovf;
    logic               lost_flag;
    logic               next_lost;
    logic               sampled;
    logic               next_sampled;
    logic               rx_low_seen;
    logic               next_rx_low_seen;
    logic               set_done;
    logic               set_ovf;
    logic               set_lost;
    logic               running;
    logic               rxd_q;
    logic               txi_q;
    logic               xtal_q;
    logic               rx_fall;
    logic               rx_rise;
    logic               tx_rise;
    logic               tx_fall;
    logic [1:0]         bus_div;
    logic [1:0]         next_bus_div;
    logic [PRE_W-1:0]   pre_cnt;
    logic [PRE_W-1:0]   next_pre_cnt;
    logic               pre_half;
    logic               next_pre_half;
    logic               pre_pulse;
    logic               cnt_tick;
    logic               cfg_src;
    logic               next_cfg_src;
    logic [PRE_W-1:0]   cfg_div;
    logic [PRE_W-1:0]   next_cfg_div;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   next_irq_status;
    logic [IRQ_W-1:0]   irq_mask;
    logic [IRQ_W-1:0]   next_irq_mask;
    logic [31:0]        next_readdata;
    logic               next_waitrequest;
    logic               fire;
    logic               wr_lane0;
    logic               ctrl_wr;
    logic [CNT_W-1:0]   target;
    logic               sample_now;

    // Bus access completes in the cycle where waitrequest is low
    assign fire     = (avs_read | avs_write) & ~avs_waitrequest;
    assign wr_lane0 = fire & avs_write & avs_byteenable[0];
    assign ctrl_wr  = wr_lane0 && avs_address == REG_CTRL;

    // Edge detection on the synchronous line inputs
    assign rx_fall = rxd_q & ~rxd;
    assign rx_rise = ~rxd_q & rxd;
    assign tx_rise = ~txi_q & internal_transmit_output;
    assign tx_fall = txi_q & ~internal_transmit_output;
    assign running = state == ST_RUN;

    // Counter clock: bus clock over four, or every second prescaler pulse
    assign cnt_tick = clk_sel ? (pre_pulse & pre_half)
                              : (bus_div == DIV_BUS_LAST);
    assign target     = clk_sel ? TARGET_PRE : TARGET_BUS;
    assign sample_now = mode == MODE_ARB && running && count == target && !sampled;

    // Prescaler source and divider
    always_comb
    begin
        next_bus_div  = bus_div + 2'h1;
        next_pre_cnt  = pre_cnt;
        next_pre_half = pre_half;
        pre_pulse     = 1'b0;
        if (cfg_src ? (~xtal_q & crystal_clock) : 1'b1)
        begin
            if (pre_cnt + PRE_W'(1) >= cfg_div)
            begin
                next_pre_cnt  = '0;
                pre_pulse     = 1'b1;
                next_pre_half = ~pre_half;
            end
            else
            begin
                next_pre_cnt = pre_cnt + PRE_W'(1);
            end
        end
    end

    // Clock dividers and input history
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bus_div  <= 2'h0;
            pre_cnt  <= '0;
            pre_half <= 1'b0;
            rxd_q    <= 1'b1;
            txi_q    <= 1'b1;
            xtal_q   <= 1'b0;
        end
        else if (ce)
        begin
            bus_div  <= next_bus_div;
            pre_cnt  <= next_pre_cnt;
            pre_half <= next_pre_half;
            rxd_q    <= rxd;
            txi_q    <= internal_transmit_output;
            xtal_q   <= crystal_clock;
        end
    end

    // Arbiter core: mode sequencing, counting and flags
    always_comb
    begin
        next_state       = state;
        next_count       = count;
        next_mode        = mode;
        next_clk_sel     = clk_sel;
        next_done        = done_flag;
        next_ovf         = ovf_flag;
        next_lost        = lost_flag;
        next_sampled     = sampled;
        next_rx_low_seen = rx_low_seen;
        set_done         = 1'b0;
        set_ovf          = 1'b0;
        set_lost         = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (mode == MODE_BITTIME || mode == MODE_ARB)
                    next_state = ST_ARMED;
            end
            ST_ARMED:
            begin
                if (mode == MODE_BITTIME)
                begin
                    if (clk_sel ? !rxd : rx_fall)
                        next_state = ST_RUN;
                end
                else if (mode == MODE_ARB)
                begin
                    if (tx_rise)
                    begin
                        next_state       = ST_RUN;
                        next_count       = '0;
                        next_sampled     = 1'b0;
                        next_rx_low_seen = 1'b0;
                    end
                end
                else
                    next_state = ST_IDLE;
            end
            ST_RUN:
            begin
                if (cnt_tick)
                begin
                    next_count = count + CNT_W'(1);
                    if (count == CNT_MAX)
                        set_ovf = 1'b1;
                end
                if (mode == MODE_BITTIME)
                begin
                    if (clk_sel ? rx_rise : rx_fall)
                    begin
                        next_state = ST_STOP;
                        next_count = count;
                        set_done   = 1'b1;
                    end
                end
                else if (mode == MODE_ARB)
                begin
                    if (!rxd)
                        next_rx_low_seen = 1'b1;
                    if (sample_now)
                    begin
                        next_sampled = 1'b1;
                        set_lost     = !rxd;
                    end
                    if (tx_rise)
                    begin
                        next_count       = '0;
                        next_sampled     = 1'b0;
                        next_rx_low_seen = 1'b0;
                    end
                    else if (tx_fall && !rx_low_seen)
                    begin
                        next_count = '0;
                        next_state = ST_ARMED;
                    end
                end
                else
                    next_state = ST_IDLE;
            end
            ST_STOP:
            begin
                if (mode != MODE_BITTIME)
                    next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        // Flags are sticky; a set in the clearing cycle wins
        next_done = next_done | set_done;
        next_ovf  = next_ovf | set_ovf;
        next_lost = next_lost | set_lost;
        if (ctrl_wr)
        begin
            next_mode        = avs_writedata[B_MODE_HI:B_MODE_LO];
            next_clk_sel     = avs_writedata[B_CLK_SEL];
            next_count       = '0;
            next_done        = set_done;
            next_ovf         = set_ovf;
            next_sampled     = 1'b0;
            next_rx_low_seen = 1'b0;
            if (!avs_writedata[B_MODE_HI])
                next_lost = set_lost;
            if (next_mode == MODE_BITTIME || next_mode == MODE_ARB)
                next_state = ST_ARMED;
            else
                next_state = ST_IDLE;
        end
        if (next_state == ST_IDLE)
            next_count = '0;
    end

    // Arbiter core registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state       <= ST_IDLE;
            count       <= '0;
            mode        <= MODE_RST;
            clk_sel     <= 1'b0;
            done_flag   <= 1'b0;
            ovf_flag    <= 1'b0;
            lost_flag   <= 1'b0;
            sampled     <= 1'b0;
            rx_low_seen <= 1'b0;
            txd_pin     <= 1'b1;
        end
        else if (ce)
        begin
            state       <= next_state;
            count       <= next_count;
            mode        <= next_mode;
            clk_sel     <= next_clk_sel;
            done_flag   <= next_done;
            ovf_flag    <= next_ovf;
            lost_flag   <= next_lost;
            sampled     <= next_sampled;
            rx_low_seen <= next_rx_low_seen;
            txd_pin     <= lost_flag | internal_transmit_output;
        end
    end

    // Bus slave, configuration and interrupt registers
    always_comb
    begin
        next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
        next_readdata    = avs_readdata;
        next_cfg_src     = cfg_src;
        next_cfg_div     = cfg_div;
        next_irq_mask    = irq_mask;
        next_irq_status  = irq_status;
        if (wr_lane0 && avs_address == REG_IRQ_STATUS)
            next_irq_status = irq_status & ~avs_writedata[IRQ_W-1:0];
        next_irq_status[IRQ_DONE] = next_irq_status[IRQ_DONE] | set_done;
        next_irq_status[IRQ_OVF]  = next_irq_status[IRQ_OVF] | set_ovf;
        next_irq_status[IRQ_LOST] = next_irq_status[IRQ_LOST] | set_lost;
        if (wr_lane0 && avs_address == REG_IRQ_MASK)
            next_irq_mask = avs_writedata[IRQ_W-1:0];
        if (wr_lane0 && avs_address == REG_CONFIG)
            next_cfg_src = avs_writedata[CFG_SRC];
        if (fire && avs_write && avs_byteenable[1] && avs_address == REG_CONFIG)
            next_cfg_div = avs_writedata[CFG_DIV_LSB +: PRE_W];
        if (avs_read && avs_waitrequest)
        begin
            next_readdata = 32'h0000_0000;
            case (avs_address)
                REG_CTRL:
                begin
                    next_readdata[B_MODE_HI:B_MODE_LO] = mode;
                    next_readdata[B_LOST]    = lost_flag;
                    next_readdata[B_CLK_SEL] = clk_sel;
                    next_readdata[B_DONE]    = done_flag;
                    next_readdata[B_RUN]     = running;
                    next_readdata[B_OVF]     = ovf_flag;
                    next_readdata[B_MSB]     = count[CNT_W-1];
                end
                REG_COUNT_LOW:  next_readdata[7:0] = count[7:0];
                REG_CONFIG:
                begin
                    next_readdata[CFG_SRC] = cfg_src;
                    next_readdata[CFG_DIV_LSB +: PRE_W] = cfg_div;
                end
                REG_IRQ_STATUS: next_readdata[IRQ_W-1:0] = irq_status;
                REG_IRQ_MASK:   next_readdata[IRQ_W-1:0] = irq_mask;
                default:        next_readdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus slave and interrupt registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            cfg_src         <= 1'b0;
            cfg_div         <= PRE_W'(CFG_DIV_RST);
            irq_status      <= '0;
            irq_mask        <= '0;
            irq             <= 1'b0;
        end
        else if (ce)
        begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
            cfg_src         <= next_cfg_src;
            cfg_div         <= next_cfg_div;
            irq_status      <= next_irq_status;
            irq_mask        <= next_irq_mask;
            irq             <= |(irq_status & irq_mask);
        end
    end

    // Checks on the arbiter behaviour
    mode_idle_a: assert property (@(posedge mclk) disable iff (rst)
        mode == MODE_IDLE |=> count == '0)
        else $error("counter not held in idle mode");
    ctrl_clear_a: assert property (@(posedge mclk) disable iff (rst)
        ce && ctrl_wr |=> count == '0)
        else $error("control write did not clear count");
    run_start_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(running) |-> $past(mode) != MODE_IDLE)
        else $error("counter started while idle");
    fall_done_a: assert property (@(posedge mclk) disable iff (rst)
        ce && running && mode == MODE_BITTIME && !clk_sel && rx_fall && !ctrl_wr
        |=> done_flag && !running)
        else $error("second falling edge did not finish measurement");
    break_start_a: assert property (@(posedge mclk) disable iff (rst)
        ce && state == ST_ARMED && mode == MODE_BITTIME && clk_sel && !rxd && !ctrl_wr
        |=> running)
        else $error("low receive line did not start counter");
    tx_restart_a: assert property (@(posedge mclk) disable iff (rst)
        ce && mode == MODE_ARB && tx_rise && !ctrl_wr && state != ST_IDLE
        |=> running && count == '0)
        else $error("transmit rise did not restart counter");
    sample_lost_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sample_now && !rxd |=> lost_flag)
        else $error("low sample did not set lost flag");
    force_high_a: assert property (@(posedge mclk) disable iff (rst)
        ce && lost_flag |=> txd_pin)
        else $error("transmit pin not forced while lost");
    lost_clear_a: assert property (@(posedge mclk) disable iff (rst)
        ce && ctrl_wr && !avs_writedata[B_MODE_HI] && !set_lost
        |=> !lost_flag)
        else $error("lost flag not cleared by mode write");
    no_echo_a: assert property (@(posedge mclk) disable iff (rst)
        ce && running && mode == MODE_ARB && tx_fall && !tx_rise && !rx_low_seen
        && !ctrl_wr |=> state == ST_ARMED && count == '0)
        else $error("arbitration not restarted after early transmit low");
    wrap_a: assert property (@(posedge mclk) disable iff (rst)
        ce && running && cnt_tick && count == CNT_MAX && !rx_fall && !rx_rise
        && !tx_rise && !tx_fall && !ctrl_wr
        |=> ovf_flag && count == '0)
        else $error("overflow did not wrap and flag");

endmodule

// ### dv/sla_bus_node.sv
`timescale 1ns/1ps
// Other node on the shared single-wire line, wired-AND with a pull-up
module sla_bus_node
(
    input  wire logic txd_pin,
    input  wire logic drive_low,
    output logic      rxd
);
    // Dominant low from either node wins, recessive high via the pull-up
    assign rxd = txd_pin & ~drive_low;
endmodule

// ### dv/test_serial_line_arbiter.sv
`timescale 1ns/1ps
module test_serial_line_arbiter
    import sla_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rxd;
    logic        xtal = 1'b0;
    logic        tx_int = 1'b1;
    logic        txd_pin;
    logic        irq;
    logic        low_req = 1'b0;
    logic [31:0] q;
    int          fail_count = 0;
    int          comparisons = 0;
    // Register rows: address, write value, expected read-back
    localparam logic [4:0]  ra [8] = '{REG_CTRL, REG_CTRL, REG_CTRL, REG_CTRL,
                                      REG_CONFIG, REG_CONFIG, REG_IRQ_MASK, 5'h14};
    localparam logic [31:0] rw [8] = '{32'h50, 32'h10, 32'hD0, 32'h00,
                                      32'h301, 32'h100, 32'h7, 32'hFF};
    localparam logic [31:0] rx [8] = '{32'h50, 32'h10, 32'hD0, 32'h00,
                                      32'h301, 32'h100, 32'h7, 32'h0};

    // Clock and a slower crystal level
    always #2 mclk = ~mclk;
    always @(posedge mclk) xtal <= ~xtal;

    sla_arbiter dut_u (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxd(rxd), .crystal_clock(xtal),
        .internal_transmit_output(tx_int), .txd_pin(txd_pin), .irq(irq));
    sla_bus_node node_u (.txd_pin(txd_pin), .drive_low(low_req), .rxd(rxd));

    // One compare, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do
        begin
            @(posedge mclk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog far beyond the expected run length
    initial
    begin
        #60000;
        fail_count++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        cyc(3);
        rst <= 1'b0;
        cyc(1);
        chk(32'(txd_pin), 32'h1);
        bus(0, REG_CTRL, 0);
        chk(q, 32'h0);
        bus(0, REG_COUNT_LOW, 0);
        chk(q, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            bus(1, ra[i], rw[i]);
            bus(0, ra[i], 0);
            chk(q, rx[i]);
        end
        // Bit time: falling edges 200 enabled cycles apart, 4 per tick; ce low freezes 40
        bus(1, REG_CTRL, 32'h40);
        cyc(5);
        low_req <= 1'b1;
        cyc(8);
        low_req <= 1'b0;
        cyc(96);
        ce <= 1'b0;
        cyc(40);
        ce <= 1'b1;
        cyc(96);
        low_req <= 1'b1;
        cyc(8);
        low_req <= 1'b0;
        bus(0, REG_CTRL, 0);
        chk(q, 32'h48);
        bus(0, REG_COUNT_LOW, 0);
        chk(32'(q >= 48 && q <= 52), 32'h1);
        bus(0, REG_IRQ_STATUS, 0);
        chk(q, 32'h1);
        chk(32'(irq), 32'h1);
        bus(1, REG_IRQ_STATUS, 32'h1);
        cyc(3);
        chk(32'(irq), 32'h0);
        bus(1, REG_CTRL, 0);
        bus(0, REG_CTRL, 0);
        chk(q, 32'h0);
        // Overflow: one falling edge, then run past 512 ticks
        bus(1, REG_CTRL, 32'h40);
        cyc(3);
        low_req <= 1'b1;
        cyc(8);
        low_req <= 1'b0;
        cyc(2100);
        bus(0, REG_CTRL, 0);
        chk(q & 32'hFE, 32'h46);
        bus(0, REG_COUNT_LOW, 0);
        chk(32'(q < 32'h20), 32'h1);
        bus(1, REG_CTRL, 0);
        bus(0, REG_CTRL, 0);
        chk(q, 32'h0);
        // Break length, select 1: bus source ticks every 2 cycles, crystal every 4
        for (int k = 0; k < 2; k++)
        begin
            bus(1, REG_CONFIG, k ? 32'h1 : 32'h100);
            low_req <= 1'b1;
            bus(1, REG_CTRL, 32'h50);
            cyc(100);
            low_req <= 1'b0;
            cyc(4);
            bus(0, REG_CTRL, 0);
            chk(q, 32'h58);
            bus(0, REG_COUNT_LOW, 0);
            chk(32'(q >= (k ? 23 : 48) && q <= (k ? 27 : 52)), 32'h1);
            bus(1, REG_CTRL, 0);
        end
        bus(1, REG_IRQ_STATUS, 32'h7);
        // Arbitration: other node dominant, sample at count 38h
        bus(1, REG_CTRL, 32'h80);
        tx_int <= 1'b0;
        cyc(10);
        tx_int <= 1'b1;
        cyc(30);
        low_req <= 1'b1;
        cyc(150);
        bus(0, REG_CTRL, 0);
        chk(q & 32'h20, 32'h0);
        cyc(80);
        bus(0, REG_CTRL, 0);
        chk(q & 32'hE0, 32'hA0);
        tx_int <= 1'b0;
        cyc(3);
        chk(32'(txd_pin), 32'h1);
        bus(1, REG_CTRL, 0);
        cyc(3);
        chk(32'(txd_pin), 32'h0);
        bus(0, REG_CTRL, 0);
        chk(q, 32'h0);
        // Reset right after a bit time mode write, before the counter starts
        bus(1, REG_CTRL, 32'h50);
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(1);
        bus(0, REG_CTRL, 0);
        chk(q, 32'h0);
        bus(0, REG_CONFIG, 0);
        chk(q, 32'h100);
        bus(0, REG_IRQ_STATUS, 0);
        chk(q, 32'h0);
        print_verdict();
    end
endmodule
